/* File: cxc_pkg.sv */
package cxc_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] CXC_OFF_IDENT   = 8'h00; // identifier, read only
    localparam logic [7:0] CXC_OFF_IRQEN   = 8'h04; // internal irq enable mask
    localparam logic [7:0] CXC_OFF_EXCCTL  = 8'h08; // exception control
    localparam logic [7:0] CXC_OFF_FAULT   = 8'h0c; // faulting_address_holder
    localparam logic [7:0] CXC_OFF_BUILD   = 8'h10; // build options, read only
    localparam logic [7:0] CXC_OFF_MPU     = 8'h14; // protection sizing, read only
    localparam logic [7:0] CXC_OFF_STATUS  = 8'h18; // live status, read only

    // ==========================================================
    // exception control field layout
    localparam int CXC_EXC_REASON_LSB = 2;   // exception_reason_code position
    localparam int CXC_EXC_REASON_W   = 5;   // exception_reason_code width
    localparam int CXC_EXC_VALID_BIT  = 31;  // sticky: an exception was taken
    localparam int CXC_EXC_CHECK_BIT  = 0;   // software check enable

    // ==========================================================
    // reset values
    localparam logic [31:0] CXC_RST_IRQEN  = 32'h0000_0000;
    localparam logic [31:0] CXC_RST_EXCCTL = 32'h0000_0001; // checks on
    localparam logic [31:0] CXC_RST_FAULT  = 32'h0000_0000;

    // ==========================================================
    // exception reason codes
    localparam logic [4:0] CXC_RSN_NONE    = 5'h00;
    localparam logic [4:0] CXC_RSN_ILLEGAL = 5'h05;
    localparam logic [4:0] CXC_RSN_MISDATA = 5'h07;
    localparam logic [4:0] CXC_RSN_MISDEST = 5'h08;
    localparam logic [4:0] CXC_RSN_DIVERR  = 5'h09;

    // ==========================================================
    // divide corner values
    localparam logic [31:0] CXC_MOST_NEG  = 32'h8000_0000;
    localparam logic [31:0] CXC_MINUS_ONE = 32'hffff_ffff;

    // ==========================================================
    // access widths and the primary opcode that defers to opx
    typedef enum logic [1:0] {CXC_W_BYTE, CXC_W_HALF, CXC_W_WORD, CXC_W_NONE} cxc_width_t;
    localparam logic [5:0] CXC_OP_RTYPE = 6'h3a;

    // ==========================================================
    // processor-only reset states
    typedef enum logic [1:0] {CXC_RS_RUN, CXC_RS_HOLD, CXC_RS_RELEASE} cxc_rst_t;
endpackage : cxc_pkg

/* File: cxc_core_exc.sv */
// Our own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module cxc_core_exc #(
    parameter logic [31:0] IDENT_VALUE       = 32'h0000_0000, // arbitrary value
    parameter bit          HAS_ILLEGAL_CHK   = 1'b1,
    parameter bit          HAS_HW_DIVIDE     = 1'b1,
    parameter bit          HAS_DIV_CHK       = 1'b1,
    parameter bit          HAS_MISALIGN_CHK  = 1'b1,
    parameter bit          HAS_EXTRA_INFO    = 1'b1,
    parameter bit          HAS_MMU           = 1'b0,
    parameter bit          HAS_MPU           = 1'b0,
    parameter bit          HAS_RESET_REQ     = 1'b1,
    parameter bit          USE_EXT_IRQ       = 1'b0,
    parameter int          SHADOW_SETS       = 0,
    parameter int          PROC_ID_BITS      = 10,
    parameter int          TLB_ENTRIES       = 128,
    parameter int          TLB_WAYS          = 16,
    parameter int          UDTLB_ENTRIES     = 6,
    parameter int          UITLB_ENTRIES     = 4,
    parameter int          MPU_DATA_REGIONS  = 8,
    parameter int          MPU_INST_REGIONS  = 8,
    parameter int          MPU_DATA_MIN_LOG2 = 12,
    parameter int          MPU_INST_MIN_LOG2 = 12,
    parameter bit          MPU_USE_LIMIT     = 1'b0,
    parameter logic [63:0] LEGAL_OP_MASK     = 64'hffff_ffff_ffff_ffff,
    parameter logic [63:0] LEGAL_OPX_MASK    = 64'hffff_ffff_ffff_ffff
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // processor-only reset pair
    input  wire logic              cpu_reset_req,
    output logic                   cpu_reset_taken,
    output logic                   core_hold,
    // instruction under check
    input  wire logic              ins_valid,
    input  wire logic [31:0]       ins_pc,
    input  wire logic [5:0]        ins_op,
    input  wire logic [5:0]        ins_opx,
    input  wire logic              ins_is_break,
    input  wire logic              ins_is_div,
    input  wire logic              ins_div_signed,
    input  wire logic [31:0]       div_dividend,
    input  wire logic [31:0]       div_divisor,
    input  wire cxc_pkg::cxc_width_t ls_width,
    input  wire logic [31:0]       ls_addr,
    input  wire logic              ins_is_jump,
    input  wire logic [31:0]       jump_target,
    // verdict to the pipeline
    output logic                   exc_take,
    output logic [4:0]             exc_reason,
    output logic                   wb_suppress,
    // interrupts
    input  wire logic [31:0]       irq_lines,
    input  wire logic              external_irq_controller_port_req,
    input  wire logic [5:0]        external_irq_controller_port_level,
    output logic                   irq_take,
    output logic [5:0]             irq_level
);

    // ==========================================================
    // build-time sizing, clamped to legal ranges
    function automatic int clamp(input int v, input int lo, input int hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    localparam int SETS_C  = clamp(SHADOW_SETS, 0, 63);
    localparam int DREG_C  = clamp(MPU_DATA_REGIONS, 2, 32);
    localparam int IREG_C  = clamp(MPU_INST_REGIONS, 2, 32);
    localparam int DMIN_C  = clamp(MPU_DATA_MIN_LOG2, 6, 20);
    localparam int IMIN_C  = clamp(MPU_INST_MIN_LOG2, 6, 20);
    localparam bit PROT    = HAS_MMU | HAS_MPU;
    localparam bit ILL_ON  = HAS_ILLEGAL_CHK | PROT;
    localparam bit DIV_ON  = HAS_HW_DIVIDE & HAS_DIV_CHK;
    localparam bit MIS_ON  = HAS_MISALIGN_CHK | PROT;
    localparam bit INFO_ON = HAS_EXTRA_INFO | PROT;

    // ==========================================================
    // register state
    logic [31:0]      irqen_ff;     // internal irq enable mask
    logic [31:0]      nxt_irqen;
    logic             check_ff;     // software check enable
    logic             nxt_check;
    logic             excv_ff;      // sticky exception seen
    logic             nxt_excv;
    logic [4:0]       reason_ff;    // exception_reason_code
    logic [4:0]       nxt_reason;
    logic [31:0]      fault_ff;     // faulting_address_holder
    logic [31:0]      nxt_fault;
    logic             rq_s1_ff;     // reset request synchroniser
    logic             rq_s2_ff;
    cxc_pkg::cxc_rst_t rst_st_ff;   // processor-only reset state
    cxc_pkg::cxc_rst_t nxt_rst_st;

    // ==========================================================
    // apb decode
    wire        apb_wr     = psel & penable & pwrite;
    wire        hit_ident  = (paddr == cxc_pkg::CXC_OFF_IDENT);
    wire        hit_irqen  = (paddr == cxc_pkg::CXC_OFF_IRQEN);
    wire        hit_excctl = (paddr == cxc_pkg::CXC_OFF_EXCCTL);
    wire        hit_fault  = (paddr == cxc_pkg::CXC_OFF_FAULT);
    wire        hit_build  = (paddr == cxc_pkg::CXC_OFF_BUILD);
    wire        hit_mpu    = (paddr == cxc_pkg::CXC_OFF_MPU);
    wire        hit_status = (paddr == cxc_pkg::CXC_OFF_STATUS);
    wire        hit_any    = hit_ident | hit_irqen | hit_excctl | hit_fault |
                             hit_build | hit_mpu | hit_status;
    wire        wr_irqen   = apb_wr & hit_irqen;
    wire        wr_excctl  = apb_wr & hit_excctl;

    // ==========================================================
    // check enables: software gate on top of build options
    wire        gate    = check_ff & ~core_hold;
    wire        ill_en  = ILL_ON & gate;
    wire        div_en  = DIV_ON & gate;
    wire        mis_en  = MIS_ON & gate;

    // ==========================================================
    // illegal encoding: rtype defers to the extension field
    wire        op_legal  = LEGAL_OP_MASK[ins_op];
    wire        opx_legal = LEGAL_OPX_MASK[ins_opx];
    wire        is_rtype  = (ins_op == cxc_pkg::CXC_OP_RTYPE);
    wire        enc_bad   = is_rtype ? ~opx_legal : ~op_legal;
    wire        ill_hit   = ill_en & ins_valid & enc_bad;

    // ==========================================================
    // division errors: zero divisor or signed overflow
    wire        div_zero  = (div_divisor == 32'h0000_0000);
    wire        div_ovf   = ins_div_signed &
                            (div_dividend == cxc_pkg::CXC_MOST_NEG) &
                            (div_divisor == cxc_pkg::CXC_MINUS_ONE);
    wire        div_hit   = div_en & ins_valid & ins_is_div &
                            (div_zero | div_ovf);

    // ==========================================================
    // misaligned data: byte always aligned
    wire        half_bad  = (ls_width == cxc_pkg::CXC_W_HALF) & ls_addr[0];
    wire        word_bad  = (ls_width == cxc_pkg::CXC_W_WORD) & (ls_addr[1:0] != 2'b00);
    wire        mdat_hit  = mis_en & ins_valid & (half_bad | word_bad);

    // ==========================================================
    // misaligned jump destination
    wire        mdst_hit  = mis_en & ins_valid & ins_is_jump &
                            (jump_target[1:0] != 2'b00);

    // ==========================================================
    // priority: illegal, divide, data, destination
    wire        any_hit   = ill_hit | div_hit | mdat_hit | mdst_hit;
    wire [4:0]  hit_rsn   = ill_hit  ? cxc_pkg::CXC_RSN_ILLEGAL :
                            div_hit  ? cxc_pkg::CXC_RSN_DIVERR  :
                            mdat_hit ? cxc_pkg::CXC_RSN_MISDATA :
                                       cxc_pkg::CXC_RSN_MISDEST;
    wire        has_addr  = ~ill_hit & ~div_hit;
    wire [31:0] hit_addr  = mdat_hit ? ls_addr : jump_target;

    // verdict to pipeline, combinational so it kills in the same cycle
    assign exc_take    = any_hit;
    assign exc_reason  = hit_rsn;
    assign wb_suppress = any_hit;

    // ==========================================================
    // exception control next state; hardware set beats software clear
    always_comb begin
        nxt_check  = check_ff;
        nxt_excv   = excv_ff;
        nxt_reason = reason_ff;
        if (wr_excctl) begin
            nxt_check = pwdata[cxc_pkg::CXC_EXC_CHECK_BIT];
            if (pwdata[cxc_pkg::CXC_EXC_VALID_BIT]) begin
                nxt_excv = 1'b0;                    // write one clears
            end
        end
        if (any_hit & ~ins_is_break & INFO_ON) begin
            nxt_excv   = 1'b1;
            nxt_reason = hit_rsn;
        end
    end

    // faulting address only for misalignment types
    always_comb begin
        nxt_fault = fault_ff;
        if (apb_wr & hit_fault) begin
            nxt_fault = pwdata;                     // software may preset
        end
        if (any_hit & has_addr) begin
            nxt_fault = hit_addr;
        end
    end

    // irq enable mask written by software
    assign nxt_irqen = wr_irqen ? pwdata : irqen_ff;

    // ==========================================================
    // exception registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            check_ff  <= cxc_pkg::CXC_RST_EXCCTL[cxc_pkg::CXC_EXC_CHECK_BIT];
            excv_ff   <= 1'b0;
            reason_ff <= cxc_pkg::CXC_RSN_NONE;
            fault_ff  <= cxc_pkg::CXC_RST_FAULT;
            irqen_ff  <= cxc_pkg::CXC_RST_IRQEN;
        end else begin
            check_ff  <= nxt_check;
            excv_ff   <= nxt_excv;
            reason_ff <= nxt_reason;
            fault_ff  <= nxt_fault;
            irqen_ff  <= nxt_irqen;
        end
    end

    // ==========================================================
    // processor-only reset: request synchronised, core held while asserted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rq_s1_ff <= 1'b0;
            rq_s2_ff <= 1'b0;
        end else begin
            rq_s1_ff <= cpu_reset_req & HAS_RESET_REQ;
            rq_s2_ff <= rq_s1_ff;
        end
    end

    // hold while requested, release one cycle after the request drops
    always_comb begin
        nxt_rst_st = rst_st_ff;
        unique case (rst_st_ff)
            cxc_pkg::CXC_RS_RUN: begin
                if (rq_s2_ff) nxt_rst_st = cxc_pkg::CXC_RS_HOLD;
            end
            cxc_pkg::CXC_RS_HOLD: begin
                if (!rq_s2_ff) nxt_rst_st = cxc_pkg::CXC_RS_RELEASE;
            end
            cxc_pkg::CXC_RS_RELEASE: begin
                nxt_rst_st = rq_s2_ff ? cxc_pkg::CXC_RS_HOLD : cxc_pkg::CXC_RS_RUN;
            end
            default: nxt_rst_st = cxc_pkg::CXC_RS_RUN;
        endcase
    end

    // reset state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_st_ff <= cxc_pkg::CXC_RS_RUN;
        end else begin
            rst_st_ff <= nxt_rst_st;
        end
    end

    // taken lasts the HOLD state only; core_hold also covers RELEASE
    assign cpu_reset_taken = (rst_st_ff == cxc_pkg::CXC_RS_HOLD);
    assign core_hold       = (rst_st_ff != cxc_pkg::CXC_RS_RUN);

    // ==========================================================
    // interrupt scheme: exactly one is built
    logic [5:0] int_lvl;   // highest enabled internal line
    logic       int_req;
    always_comb begin
        int_lvl = 6'h00;
        int_req = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (irq_lines[i] & irqen_ff[i]) begin
                int_lvl = 6'(i);
                int_req = 1'b1;
            end
        end
    end

    generate
        if (USE_EXT_IRQ) begin : g_ext
            assign irq_take  = external_irq_controller_port_req & ~core_hold;
            assign irq_level = external_irq_controller_port_level;
        end else begin : g_int
            assign irq_take  = int_req & ~core_hold;
            assign irq_level = int_lvl;
        end
    endgenerate

    // ==========================================================
    // read-only views of build configuration, exception control and status
    wire [31:0] build_word = {
        2'b00,
        6'(SETS_C),
        5'(PROC_ID_BITS),
        8'(TLB_ENTRIES >> 2),
        5'(TLB_WAYS),
        3'(UDTLB_ENTRIES >> 1),
        3'(UITLB_ENTRIES >> 1)
    };
    wire [31:0] mpu_word = {
        5'b00000,
        MPU_USE_LIMIT,
        PROT, USE_EXT_IRQ, HAS_MPU, HAS_MMU,
        6'(DREG_C), 6'(IREG_C),
        5'(DMIN_C), 5'(IMIN_C)
    };
    wire [31:0] exc_word   = {excv_ff, 24'h00_0000, reason_ff, 1'b0, check_ff};
    wire [31:0] stat_word  = {27'h000_0000, cpu_reset_taken, core_hold,
                              DIV_ON, MIS_ON, ILL_ON};

    // ==========================================================
    // apb read mux, zero-wait answer, error on unmapped
    assign prdata  = hit_ident  ? IDENT_VALUE :
                     hit_irqen  ? irqen_ff    :
                     hit_excctl ? exc_word    :
                     hit_fault  ? fault_ff    :
                     hit_build  ? build_word  :
                     hit_mpu    ? mpu_word    :
                     hit_status ? stat_word   : 32'h0000_0000;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

endmodule : cxc_core_exc

`default_nettype wire

/* File: cxc_core_exc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port level checks of the exception block
module cxc_core_exc_monitor #(
    parameter logic [31:0] IDENT_VALUE = 32'h0000_0000 // arbitrary value
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        cpu_reset_req,
    input wire logic        cpu_reset_taken,
    input wire logic        core_hold,
    input wire logic        ins_valid,
    input wire logic        ins_is_div,
    input wire logic        ins_div_signed,
    input wire logic [31:0] div_dividend,
    input wire logic [31:0] div_divisor,
    input wire logic [1:0]  ls_width,
    input wire logic [31:0] ls_addr,
    input wire logic        ins_is_jump,
    input wire logic [31:0] jump_target,
    input wire logic        exc_take,
    input wire logic [4:0]  exc_reason,
    input wire logic        wb_suppress,
    input wire logic [31:0] irq_lines,
    input wire logic        irq_take
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // read access phase
    wire rd_acc = psel & penable & ~pwrite;
    // signed overflow corner
    wire ovf = ins_div_signed & (div_dividend == cxc_pkg::CXC_MOST_NEG)
               & (div_divisor == cxc_pkg::CXC_MINUS_ONE);
    // exception with a given code
    wire is_div_x = exc_take & (exc_reason == cxc_pkg::CXC_RSN_DIVERR);
    wire is_dat_x = exc_take & (exc_reason == cxc_pkg::CXC_RSN_MISDATA);
    wire is_dst_x = exc_take & (exc_reason == cxc_pkg::CXC_RSN_MISDEST);
    // ==========================================
    // assertions
    a_ident_read: assert property (
        rd_acc && paddr == cxc_pkg::CXC_OFF_IDENT |-> prdata == IDENT_VALUE)
        else $error("bad identifier");
    a_div_cause: assert property (
        is_div_x |-> ins_is_div && (div_divisor == 32'h0000_0000 || ovf))
        else $error("div error without cause");
    a_ovf_faults: assert property (
        ins_valid && ins_is_div && ovf && !core_hold |-> exc_take)
        else $error("overflow not trapped");
    a_misdata_cause: assert property (
        is_dat_x |-> (ls_width == cxc_pkg::CXC_W_HALF && ls_addr[0])
                  || (ls_width == cxc_pkg::CXC_W_WORD && ls_addr[1:0] != 2'h0))
        else $error("misdata code without cause");
    a_misdest_cause: assert property (
        is_dst_x |-> ins_is_jump && jump_target[1:0] != 2'h0)
        else $error("misdest code without cause");
    a_wb_blocked: assert property (wb_suppress == exc_take)
        else $error("suppress differs from take");
    a_take_needs_ins: assert property (exc_take |-> ins_valid)
        else $error("take without instruction");
    a_reset_ack: assert property ($rose(cpu_reset_req) |-> ##[1:4] cpu_reset_taken)
        else $error("reset not taken");
    a_reset_drop: assert property ($fell(cpu_reset_req) |-> ##[1:5] !cpu_reset_taken)
        else $error("reset taken stuck");
    a_hold_cover: assert property (cpu_reset_taken |-> core_hold)
        else $error("core not held");
    a_irq_source: assert property (irq_take |-> irq_lines != 32'h0000_0000)
        else $error("irq with no line");
    // ==========================================
    // main scenario covers
    c_div: cover property (is_div_x);
    c_dat: cover property (is_dat_x);
    c_rst: cover property ($rose(cpu_reset_taken));
endmodule : cxc_core_exc_monitor

bind cxc_core_exc cxc_core_exc_monitor #(.IDENT_VALUE(IDENT_VALUE)) u_mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .cpu_reset_req,
    .cpu_reset_taken, .core_hold, .ins_valid, .ins_is_div, .ins_div_signed,
    .div_dividend, .div_divisor, .ls_width(ls_width), .ls_addr, .ins_is_jump,
    .jump_target, .exc_take, .exc_reason, .wb_suppress, .irq_lines, .irq_take);
`default_nettype wire

/* File: cxc_far_end.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// reset requester and outside irq controller
module cxc_far_end (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       want_reset,
    input  wire logic       want_irq,
    input  wire logic [5:0] want_level,
    output logic            cpu_reset_req,
    output logic            ext_req,
    output logic [5:0]      ext_level
);
    logic       req_ff; // reset request level
    logic       irq_ff; // outside irq request
    logic [5:0] lvl_ff; // requested level
    // requests change just after the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ff <= 1'b0;
            irq_ff <= 1'b0;
            lvl_ff <= 6'h2a;
        end else begin
            req_ff <= want_reset;
            irq_ff <= want_irq;
            lvl_ff <= want_level;
        end
    end
    assign cpu_reset_req = req_ff;
    assign ext_req       = irq_ff;
    assign ext_level     = lvl_ff;
endmodule : cxc_far_end
`default_nettype wire

/* File: cxc_core_exc_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// self-checking bench of the exception block
module cxc_core_exc_tb_top;
    localparam logic [31:0] ID = 32'h5a5a_0001; // arbitrary value
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, ins_pc = 32'h0, dd = 32'h0, ds = 32'h0;
    logic [31:0] ls_addr = 32'h0, jump_target = 32'h0, irq_lines = 32'h0;
    logic pready, pslverr, rreq, rtaken, hold, exc_take, wb_sup, irq_take, ereq;
    logic ins_valid = 1'b0, is_div = 1'b0, sgn = 1'b0, is_jump = 1'b0, brk = 1'b0;
    logic want_reset = 1'b0, want_irq = 1'b0;
    logic [5:0] ins_op = 6'h00, want_level = 6'h00, elvl, irq_level;
    logic [4:0] exc_reason;
    cxc_pkg::cxc_width_t ls_width = cxc_pkg::CXC_W_NONE;
    int fail_count = 0, samples_checked = 0;
    // clock, 100 ns period
    always #50 pclk = ~pclk;
    cxc_core_exc #(.IDENT_VALUE(ID), .LEGAL_OP_MASK(64'h7fff_ffff_ffff_ffff)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cpu_reset_req(rreq), .cpu_reset_taken(rtaken), .core_hold(hold),
        .ins_valid, .ins_pc, .ins_op, .ins_opx(6'h00), .ins_is_break(brk),
        .ins_is_div(is_div), .ins_div_signed(sgn), .div_dividend(dd), .div_divisor(ds),
        .ls_width, .ls_addr, .ins_is_jump(is_jump), .jump_target, .exc_take,
        .exc_reason, .wb_suppress(wb_sup), .irq_lines,
        .external_irq_controller_port_req(ereq),
        .external_irq_controller_port_level(elvl), .irq_take, .irq_level);
    cxc_far_end u_far (.pclk, .presetn, .want_reset, .want_irq, .want_level,
        .cpu_reset_req(rreq), .ext_req(ereq), .ext_level(elvl));
    // ==========================================
    // shared tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // present the instruction, judge the verdict
    task automatic fire(input logic t, input logic [4:0] rs);
        ins_valid <= 1'b1;
        @(negedge pclk);
        chk("exc_take", {31'h0, exc_take}, {31'h0, t});
        if (t) chk("exc_reason", {27'h0, exc_reason}, {27'h0, rs});
        chk("wb_suppress", {31'h0, wb_sup}, {31'h0, t});
        @(posedge pclk);
        ins_valid <= 1'b0;
        is_div    <= 1'b0;
        is_jump   <= 1'b0;
        brk       <= 1'b0;
        ls_width  <= cxc_pkg::CXC_W_NONE;
        ins_op    <= 6'h00;
    endtask : fire
    task automatic div(input logic s, input logic [31:0] a, b, input logic t);
        @(posedge pclk);
        is_div <= 1'b1;
        sgn    <= s;
        dd     <= a;
        ds     <= b;
        fire(t, cxc_pkg::CXC_RSN_DIVERR);
    endtask : div
    task automatic mem(input cxc_pkg::cxc_width_t w, input logic [31:0] a, input logic t);
        @(posedge pclk);
        ls_width <= w;
        ls_addr  <= a;
        fire(t, cxc_pkg::CXC_RSN_MISDATA);
    endtask : mem
    task automatic jmp(input logic [31:0] a, input logic t);
        @(posedge pclk);
        is_jump     <= 1'b1;
        jump_target <= a;
        fire(t, cxc_pkg::CXC_RSN_MISDEST);
    endtask : jmp
    // ==========================================
    // scenarios
    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        apb(1'b1, cxc_pkg::CXC_OFF_IDENT, 32'h0, r, e);
        apb(1'b0, cxc_pkg::CXC_OFF_IDENT, 32'h0, r, e);
        chk("ident", r, ID);
        apb(1'b0, cxc_pkg::CXC_OFF_BUILD, 32'h0, r, e);
        chk("build", r, {8'h0, 5'd10, 8'd32, 5'd16, 3'd3, 3'd2});
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        apb(1'b0, cxc_pkg::CXC_OFF_EXCCTL, 32'h0, r, e);
        chk("excctl_rst", r, cxc_pkg::CXC_RST_EXCCTL);
    endtask : t_regs
    task automatic t_exc;
        logic [31:0] r;
        logic        e;
        div(1'b1, 32'h7, 32'h0, 1'b1);
        div(1'b0, 32'h7, 32'h0, 1'b1);
        div(1'b0, 32'h8000_0000, 32'hffff_ffff, 1'b0);
        div(1'b1, 32'h8000_0000, 32'h2, 1'b0);
        div(1'b1, 32'h8000_0000, 32'hffff_ffff, 1'b1);
        apb(1'b0, cxc_pkg::CXC_OFF_EXCCTL, 32'h0, r, e);
        chk("excctl_div", r, 32'h8000_0025);
        mem(cxc_pkg::CXC_W_BYTE, 32'h103, 1'b0);
        mem(cxc_pkg::CXC_W_HALF, 32'h102, 1'b0);
        mem(cxc_pkg::CXC_W_HALF, 32'h101, 1'b1);
        mem(cxc_pkg::CXC_W_WORD, 32'h108, 1'b0);
        mem(cxc_pkg::CXC_W_WORD, 32'h106, 1'b1);
        @(posedge pclk);
        ins_op <= 6'h3f;
        is_div <= 1'b1;
        brk    <= 1'b1;
        ds     <= 32'h0;
        fire(1'b1, cxc_pkg::CXC_RSN_ILLEGAL);
        apb(1'b0, cxc_pkg::CXC_OFF_FAULT, 32'h0, r, e);
        chk("fault_data", r, 32'h106);
        apb(1'b0, cxc_pkg::CXC_OFF_EXCCTL, 32'h0, r, e);
        chk("excctl_data", r, 32'h8000_001d);
        jmp(32'h200, 1'b0);
        jmp(32'h202, 1'b1);
        jmp(32'h201, 1'b1);
        apb(1'b0, cxc_pkg::CXC_OFF_FAULT, 32'h0, r, e);
        chk("fault_dest", r, 32'h201);
    endtask : t_exc
    task automatic t_rst;
        want_reset <= 1'b1;
        for (int i = 0; i < 10 && rtaken !== 1'b1; i++) @(posedge pclk);
        chk("reset_taken", {31'h0, rtaken}, 32'h1);
        chk("core_hold", {31'h0, hold}, 32'h1);
        want_reset <= 1'b0;
        for (int i = 0; i < 10 && rtaken !== 1'b0; i++) @(posedge pclk);
        chk("reset_drop", {31'h0, rtaken}, 32'h0);
        repeat (3) @(posedge pclk);
    endtask : t_rst
    task automatic t_irq;
        logic [31:0] r;
        logic        e;
        apb(1'b1, cxc_pkg::CXC_OFF_IRQEN, 32'h8, r, e);
        @(posedge pclk);
        irq_lines  <= 32'h4;
        want_irq   <= 1'b1;
        want_level <= 6'h05;
        @(posedge pclk);
        @(negedge pclk);
        chk("irq_masked", {31'h0, irq_take}, 32'h0);
        @(posedge pclk);
        irq_lines <= 32'hc;
        @(negedge pclk);
        chk("irq_taken", {31'h0, irq_take}, 32'h1);
        chk("irq_level", {26'h0, irq_level}, 32'h3);
    endtask : t_irq
    // ==========================================
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_exc();
        t_rst();
        t_irq();
        test_done();
    end
    // watchdog
    initial begin
        #300000;
        fail_count++;
        test_done();
    end
endmodule : cxc_core_exc_tb_top
`default_nettype wire
